// *** rtl/ees_cfg.svh ***
`ifndef EES_CFG_SVH
`define EES_CFG_SVH

// Local clock period and the figures it turns into cycle counts
`define EES_CLK_NS 100
`define EES_GLITCH_NS 50
`define EES_FILT_CYC ((`EES_GLITCH_NS + `EES_CLK_NS - 1) / `EES_CLK_NS)
`define EES_PU_NS 1000000
`define EES_PU_CYC (`EES_PU_NS / `EES_CLK_NS)
`define EES_TWR_NS 5000000
`define EES_TWR_CYC (`EES_TWR_NS / `EES_CLK_NS)

// Widths
`define EES_CNT_W 24
`define EES_FCNT_W 4
`define EES_ADDR_W 15
`define EES_PAGE_W 6
`define EES_PAGE_BYTES (1 << `EES_PAGE_W)
`define EES_FIFO_DEPTH 4

// Filtered pin positions
`define EES_PIN_N 6
`define EES_PIN_SCL 0
`define EES_PIN_SDA 1
`define EES_PIN_A0 2
`define EES_PIN_A1 3
`define EES_PIN_A2 4
`define EES_PIN_WP 5

// Slave address byte layout
`define EES_DEV_TYPE 4'ha
`define EES_RW_BIT 0
`define EES_BIT_LAST 4'h7
`define EES_BIT_ACK 4'h8

`endif

// *** rtl/ees_fifo.sv ***
module ees_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  // Pointers carry one extra lap bit; DEPTH must be a power of two
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0] wp;
    logic [PW:0] rp;
  } ees_fifo_s;

  ees_fifo_s q; // Current state
  ees_fifo_s d; // Next state

  // Full when same slot, different lap
  assign in_ready = !((q.wp[PW] != q.rp[PW]) && (q.wp[PW-1:0] == q.rp[PW-1:0]));
  assign out_valid = (q.wp != q.rp);
  assign out_data = q.mem[q.rp[PW-1:0]];

  // Push and pop may share a cycle
  always_comb begin
    d = q;
    if (in_valid && in_ready) begin
      d.mem[q.wp[PW-1:0]] = in_data;
      d.wp = q.wp + (PW+1)'(1);
    end
    if (out_valid && out_ready) begin
      d.rp = q.rp + (PW+1)'(1);
    end
  end

  // Register the copy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// *** rtl/ees_pin_filter.sv ***
`include "ees_cfg.svh"

module ees_pin_filter #(
  parameter int WIDTH = `EES_PIN_N,
  parameter int FILT_CYC = `EES_FILT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_clean
);
  import ees_pkg::*;

  ees_filt_s [WIDTH-1:0] q; // Per-channel state
  ees_filt_s [WIDTH-1:0] d; // Next state

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_ch
      // Two-stage sync, then a level must persist before it is taken
      always_comb begin
        d[i] = q[i];
        d[i].meta = pin_raw[i];
        d[i].sync = q[i].meta;
        if (q[i].sync == q[i].clean) begin
          d[i].cnt = '0;
        end else if (q[i].cnt == ees_fcnt_t'(FILT_CYC)) begin
          // Held longer than a noise pulse can last
          d[i].clean = q[i].sync;
          d[i].cnt = '0;
        end else begin
          d[i].cnt = q[i].cnt + ees_fcnt_t'(1);
        end
      end

      // Register the channel
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          q[i] <= '0;
        end else begin
          q[i] <= d[i];
        end
      end

      assign pin_clean[i] = q[i].clean;
    end
  endgenerate
endmodule

// *** rtl/ees_pkg.sv ***
`include "ees_cfg.svh"

package ees_pkg;
  typedef logic [`EES_ADDR_W-1:0] ees_maddr_t;
  typedef logic [7:0] ees_byte_t;
  typedef logic [`EES_CNT_W-1:0] ees_cnt_t;
  typedef logic [`EES_FCNT_W-1:0] ees_fcnt_t;
  typedef logic [`EES_PAGE_W-1:0] ees_pidx_t;

  // Transfer phase of the slave port
  typedef enum logic [2:0] {
    EES_IDLE = 3'h0,
    EES_DEV = 3'h1,
    EES_AHI = 3'h2,
    EES_ALO = 3'h3,
    EES_WDAT = 3'h4,
    EES_RDAT = 3'h5,
    EES_WAIT = 3'h6
  } ees_phase_e;

  // One filtered pin channel
  typedef struct packed {
    logic meta;
    logic sync;
    logic clean;
    ees_fcnt_t cnt;
  } ees_filt_s;

  // Whole state of the slave port
  typedef struct packed {
    ees_phase_e ph;
    logic [3:0] bitcnt;
    logic in_ack;
    logic sda_oe_n;
    logic sda_out;
    ees_byte_t sh;
    ees_maddr_t addr;
    logic [`EES_ADDR_W-`EES_PAGE_W-1:0] page_base;
    logic [`EES_PAGE_BYTES-1:0][7:0] page;
    logic [`EES_PAGE_BYTES-1:0] pvalid;
    logic wp_rej;
    logic wdirty;
    logic commit;
    ees_pidx_t cidx;
    ees_cnt_t busy_cnt;
    ees_cnt_t pu_cnt;
    logic ready;
    logic scl_p;
    logic sda_p;
    logic ow_valid;
    ees_maddr_t ow_addr;
    ees_byte_t ow_data;
  } ees_port_s;
endpackage

// *** rtl/ees_slave_port.sv ***
`include "ees_cfg.svh"

module ees_slave_port #(
  parameter int PU_CYC = `EES_PU_CYC,
  parameter int TWR_CYC = `EES_TWR_CYC,
  parameter int FIFO_DEPTH = `EES_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic write_protect,
  output ees_pkg::ees_maddr_t mem_rd_addr,
  input wire ees_pkg::ees_byte_t mem_rd_data,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output ees_pkg::ees_maddr_t mem_wr_addr,
  output ees_pkg::ees_byte_t mem_wr_data,
  output logic bus_ready
);
  import ees_pkg::*;

  localparam int FW = `EES_ADDR_W + 8; // Address plus data per FIFO word

  ees_port_s q; // Registered state
  ees_port_s d; // Next state

  logic [`EES_PIN_N-1:0] pin_raw; // Pins before the filter
  logic [`EES_PIN_N-1:0] pin; // Synced, de-glitched pins
  logic scl; // Filtered clock level
  logic sda; // Filtered data level
  logic scl_rise; // Clock edge events
  logic scl_fall;
  logic start_ev; // Bus conditions
  logic stop_ev;
  logic rx_ph; // Phase in which we receive bytes
  logic busy; // Internal write in progress
  logic ack; // We acknowledge this byte
  logic [2:0] dev_sel; // Address select levels
  logic push_v; // Commit offers a word
  logic fifo_in_ready; // FIFO can take a word
  logic [FW-1:0] fifo_in_data; // Word from the page buffer
  logic fifo_out_valid; // FIFO holds a word
  logic fifo_out_ready; // Output stage can take it
  logic [FW-1:0] fifo_out_data; // Word for the output stage

  // All pins go through sync and glitch filter; undriven selects and
  // protect come in low, the pull-down is resolved at the pin
  assign pin_raw = {write_protect, addr_select_bit2, addr_select_bit1,
                    addr_select_bit0, sda_in, scl_pin};

  ees_pin_filter #(
    .WIDTH(`EES_PIN_N),
    .FILT_CYC(`EES_FILT_CYC)
  ) u_filt (
    .clk(clk),
    .reset_n(reset_n),
    .pin_raw(pin_raw),
    .pin_clean(pin)
  );

  // Page words stream to the array through a small FIFO
  assign fifo_in_data = {q.page_base, q.cidx, q.page[q.cidx]};
  assign fifo_out_ready = !q.ow_valid || mem_wr_ready;

  ees_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(push_v),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Outputs straight from the state register
  assign sda_out = q.sda_out;
  assign sda_oe_n = q.sda_oe_n;
  assign mem_rd_addr = q.addr;
  assign mem_wr_valid = q.ow_valid;
  assign mem_wr_addr = q.ow_addr;
  assign mem_wr_data = q.ow_data;
  assign bus_ready = q.ready;

  // Next-state logic for the whole port
  always_comb begin
    d = q;
    ack = 1'b0;
    push_v = 1'b0;
    scl = pin[`EES_PIN_SCL];
    sda = pin[`EES_PIN_SDA];
    dev_sel = {pin[`EES_PIN_A2], pin[`EES_PIN_A1], pin[`EES_PIN_A0]};
    scl_rise = scl && !q.scl_p;
    scl_fall = !scl && q.scl_p;
    // Only the master makes these; we just watch for them
    start_ev = q.scl_p && scl && q.sda_p && !sda;
    stop_ev = q.scl_p && scl && !q.sda_p && sda;
    rx_ph = (q.ph == EES_DEV) || (q.ph == EES_AHI) ||
            (q.ph == EES_ALO) || (q.ph == EES_WDAT);
    busy = q.commit || (q.busy_cnt != '0);
    d.scl_p = scl;
    d.sda_p = sda;

    // Power-up wait; the bus is ignored until it ends
    if (!q.ready) begin
      if (q.pu_cnt >= ees_cnt_t'(PU_CYC)) begin
        d.ready = 1'b1;
      end else begin
        d.pu_cnt = q.pu_cnt + ees_cnt_t'(1);
      end
    end

    // Write cycle timer
    if (q.busy_cnt != '0) begin
      d.busy_cnt = q.busy_cnt - ees_cnt_t'(1);
    end

    // Commit walk: offer every loaded page byte to the FIFO
    if (q.commit) begin
      push_v = q.pvalid[q.cidx];
      if (!push_v || fifo_in_ready) begin
        d.cidx = q.cidx + ees_pidx_t'(1);
        if (q.cidx == '1) begin
          d.commit = 1'b0;
          d.pvalid = '0;
        end
      end
    end

    // Output stage toward the array
    if (q.ow_valid && mem_wr_ready) begin
      d.ow_valid = 1'b0;
    end
    if (fifo_out_valid && fifo_out_ready) begin
      d.ow_valid = 1'b1;
      d.ow_addr = fifo_out_data[FW-1:8];
      d.ow_data = fifo_out_data[7:0];
    end

    // Bus protocol
    if (!q.ready) begin
      d.ph = EES_IDLE;
    end else if (stop_ev) begin
      // A loaded page starts the internal write
      if (q.wdirty) begin
        d.commit = 1'b1;
        d.cidx = '0;
        d.busy_cnt = ees_cnt_t'(TWR_CYC);
        d.wdirty = 1'b0;
      end
      d.ph = EES_IDLE;
      d.in_ack = 1'b0;
      d.sda_oe_n = 1'b1;
      d.bitcnt = '0;
      d.wp_rej = 1'b0;
    end else if (start_ev) begin
      // Also a repeated START in mid transfer
      d.ph = EES_DEV;
      d.in_ack = 1'b0;
      d.sda_oe_n = 1'b1;
      d.bitcnt = '0;
      d.wp_rej = 1'b0;
    end else if (scl_rise) begin
      if (q.ph == EES_RDAT) begin
        // Master's answer after our byte; a high level ends the read
        if (q.in_ack && sda) begin
          d.ph = EES_WAIT;
          d.in_ack = 1'b0;
        end
      end else if (rx_ph && !q.in_ack) begin
        d.sh = {q.sh[6:0], sda};
        d.bitcnt = q.bitcnt + 4'h1;
      end
    end else if (scl_fall) begin
      if (q.in_ack) begin
        // End of the 9th clock: release, then maybe start sending
        d.in_ack = 1'b0;
        d.sda_oe_n = 1'b1;
        d.bitcnt = '0;
        if (q.ph == EES_WDAT && !q.wdirty) begin
          // Protect level strobed just before the first data byte
          d.wp_rej = pin[`EES_PIN_WP];
        end
        if (q.ph == EES_RDAT) begin
          d.sh = mem_rd_data;
          d.sda_oe_n = mem_rd_data[7];
          d.addr = q.addr + ees_maddr_t'(1);
        end
      end else if (q.ph == EES_RDAT) begin
        if (q.bitcnt == `EES_BIT_LAST) begin
          // Hand the line back for the master's answer
          d.sda_oe_n = 1'b1;
          d.in_ack = 1'b1;
          d.bitcnt = `EES_BIT_ACK;
        end else begin
          // Next bit goes out after the falling edge; a one is a release
          d.sh = {q.sh[6:0], 1'b0};
          d.sda_oe_n = q.sh[6];
          d.bitcnt = q.bitcnt + 4'h1;
        end
      end else if (rx_ph && q.bitcnt == `EES_BIT_ACK) begin
        case (q.ph)
          EES_DEV: begin
            // Type, selects and no write under way
            if (q.sh[7:4] == `EES_DEV_TYPE && q.sh[3:1] == dev_sel &&
                !busy) begin
              ack = 1'b1;
              d.ph = q.sh[`EES_RW_BIT] ? EES_RDAT : EES_AHI;
            end
          end
          EES_AHI: begin
            // Top bit of the address is ignored
            ack = 1'b1;
            d.addr[`EES_ADDR_W-1:8] = q.sh[`EES_ADDR_W-9:0];
            d.ph = EES_ALO;
          end
          EES_ALO: begin
            ack = 1'b1;
            d.addr[7:0] = q.sh;
            d.page_base = {q.addr[`EES_ADDR_W-1:8], q.sh[7:`EES_PAGE_W]};
            d.ph = EES_WDAT;
          end
          EES_WDAT: begin
            // Protected writes get no acknowledge and are dropped
            if (!q.wp_rej) begin
              ack = 1'b1;
              d.page[q.addr[`EES_PAGE_W-1:0]] = q.sh;
              d.pvalid[q.addr[`EES_PAGE_W-1:0]] = 1'b1;
              d.wdirty = 1'b1;
              // Counter stays inside the page, later bytes overwrite
              d.addr[`EES_PAGE_W-1:0] = q.addr[`EES_PAGE_W-1:0] + ees_pidx_t'(1);
            end
          end
          default: begin
            ack = 1'b0;
          end
        endcase
        if (ack) begin
          // Pull low for the whole 9th clock
          d.in_ack = 1'b1;
          d.sda_oe_n = 1'b0;
        end else begin
          d.ph = EES_WAIT;
        end
      end
    end
  end

  // Register the copy; reset also stands for loss of supply
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.sda_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule

// *** tb/ees_master.sv ***
module ees_master #(
  parameter int HALF = 800
) (
  output logic scl,
  output logic sda_oe_n,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: clock high and still, data left to the pull-up
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  // Data moves mid-low, sampled mid-high
  task automatic bit_io(input logic b, input logic gl, output logic r);
    scl = 1'b0;
    #(HALF / 2) sda_oe_n = b;
    // A spike keeps the bit length, so later edges stay on the same grid
    if (gl) begin
      scl = 1'b1;
      #50 scl = 1'b0;
      #(HALF / 2 - 50) scl = 1'b1;
    end else begin
      #(HALF / 2) scl = 1'b1;
    end
    #(HALF / 2) r = sda_line;
    #(HALF / 2);
  endtask
  // Data falls while clock high
  task automatic start();
    scl = 1'b0;
    #(HALF / 2) sda_oe_n = 1'b1;
    #(HALF / 2) scl = 1'b1;
    #HALF sda_oe_n = 1'b0;
    #HALF;
  endtask
  // Data rises while clock high, then the clock stands still
  task automatic stop();
    scl = 1'b0;
    #(HALF / 2) sda_oe_n = 1'b0;
    #(HALF / 2) scl = 1'b1;
    #HALF sda_oe_n = 1'b1;
    #HALF;
  endtask
  // Eight bits MSB first, then the acknowledge clock
  task automatic xfer(input logic [7:0] tx, input logic ack_in, input logic gl,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], gl && i == 3, rx[i]);
    bit_io(ack_in, 1'b0, ack_out);
  endtask
endmodule

// *** tb/ees_sva.sv ***
module ees_sva #(
  parameter int PU_CYC = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_pin,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic mem_wr_valid,
  input wire logic mem_wr_ready,
  input wire ees_pkg::ees_maddr_t mem_wr_addr,
  input wire ees_pkg::ees_byte_t mem_wr_data,
  input wire logic bus_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import ees_pkg::*;
  // Edges since reset release, saturating
  logic [15:0] up_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q <= 16'h0000;
    end else if (up_q != 16'hffff) begin
      up_q <= up_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_never_high: assert property (sda_out == 1'b0)
    else $error("data driven high");
  a_quiet_unready: assert property (!bus_ready |-> sda_oe_n)
    else $error("line pulled before ready");
  a_change_clk_low: assert property ($changed(sda_oe_n) |-> !scl_pin)
    else $error("data changed with clock high");
  a_ready_early: assert property ($rose(bus_ready) |-> up_q >= 16'(PU_CYC)
    && up_q <= 16'(PU_CYC + 2))
    else $error("ready at wrong time");
  a_ready_late: assert property (up_q > 16'(PU_CYC + 2) |-> bus_ready)
    else $error("ready missing");
  a_ready_stays: assert property (bus_ready |=> bus_ready)
    else $error("ready dropped");
  a_word_held: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
    && $stable(mem_wr_addr) && $stable(mem_wr_data))
    else $error("write word not held");
  a_page_kept: assert property (mem_wr_valid && $past(mem_wr_valid)
    && $past(mem_wr_ready) |-> (mem_wr_addr ^ $past(mem_wr_addr)) < 15'h0040)
    else $error("commit left its page");
endmodule

bind ees_slave_port ees_sva #(.PU_CYC(PU_CYC)) i_ees_sva (.clk(clk), .reset_n(reset_n),
  .scl_pin(scl_pin), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .mem_wr_valid(mem_wr_valid),
  .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
  .bus_ready(bus_ready));

// *** tb/serial_eeprom_i2c_slave_port_tb.sv ***
module serial_eeprom_i2c_slave_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ees_pkg::*;
  localparam int PU = 20;
  localparam int INTERNAL_WRITE_DURATION = 200;
  localparam logic [2:0] SEL = 3'b101;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wp = 1'b0;
  logic wr_ready = 1'b0;
  logic [2:0] sel = SEL;
  logic scl, m_oe_n, sda_line, sda_out, sda_oe_n, wr_valid, bus_ready;
  ees_maddr_t rd_addr, wr_addr;
  ees_byte_t rd_data, wr_data;
  ees_byte_t mem [0:32767];
  int n_fail = 0;
  int checked = 0;
  always #50 clk = ~clk;
  // Pulled-up wire: low when either side pulls
  assign sda_line = m_oe_n & (sda_oe_n | sda_out);
  assign rd_data = mem[rd_addr];
  // Array takes a word on valid and ready
  always @(posedge clk) begin
    if (wr_valid && wr_ready) begin
      mem[wr_addr] <= wr_data;
    end
  end
  ees_slave_port #(.PU_CYC(PU), .TWR_CYC(INTERNAL_WRITE_DURATION), .FIFO_DEPTH(4)) i_ees_slave_port (
    .clk(clk), .reset_n(reset_n), .scl_pin(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
    .addr_select_bit2(sel[2]), .write_protect(wp), .mem_rd_addr(rd_addr),
    .mem_rd_data(rd_data), .mem_wr_valid(wr_valid), .mem_wr_ready(wr_ready),
    .mem_wr_addr(wr_addr), .mem_wr_data(wr_data), .bus_ready(bus_ready));
  ees_master #(.HALF(800)) i_ees_master (.scl(scl), .sda_oe_n(m_oe_n), .sda_line(sda_line));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One byte out, acknowledge judged
  task automatic wb(input logic [7:0] b, input logic nak, input logic gl = 1'b0);
    logic [7:0] rx;
    logic ak;
    i_ees_master.xfer(b, 1'b1, gl, rx, ak);
    chk("ack", ak, nak);
  endtask
  function automatic logic [7:0] dev(input logic rd);
    return {4'ha, SEL, rd};
  endfunction
  // Power loss, then ready after the power-up delay
  task automatic t_reset();
    int i;
    reset_n = 1'b0;
    cyc(6);
    chk("oe_n", sda_oe_n, 1'b1);
    chk("ready", bus_ready, 1'b0);
    chk("wr_valid", wr_valid, 1'b0);
    reset_n = 1'b1;
    cyc(PU - 2);
    chk("early", bus_ready, 1'b0);
    for (i = 0; i < 8 && bus_ready !== 1'b1; i++) cyc(1);
    chk("ready", bus_ready, 1'b1);
    if (i == 8) end_sim();
    cyc(8);
  endtask
  // Every select pattern on the pins, one matches; wrong type refused
  task automatic t_sel();
    for (int s = 0; s < 8; s++) begin
      sel = 3'(s);
      cyc(8);
      i_ees_master.start();
      wb(dev(1'b0), sel != SEL);
      i_ees_master.stop();
    end
    sel = SEL;
    cyc(8);
    i_ees_master.start();
    wb({4'hb, SEL, 1'b0}, 1'b1);
    i_ees_master.stop();
  endtask
  // Spike on the clock inside a byte is no clock
  task automatic t_glitch();
    i_ees_master.start();
    wb(dev(1'b0), 1'b0, 1'b1);
    i_ees_master.stop();
  endtask
  // Page write over the page end, array stalled so the buffer fills
  task automatic t_page();
    int k;
    logic [7:0] rx;
    logic ak;
    wr_ready = 1'b0;
    i_ees_master.start();
    wb(dev(1'b0), 1'b0);
    wb(8'h81, 1'b0);
    wb(8'h3e, 1'b0);
    for (int i = 0; i < 5; i++) wb(8'h10 + 8'(i), 1'b0);
    i_ees_master.stop();
    i_ees_master.start();
    wb(dev(1'b0), 1'b1);
    i_ees_master.stop();
    chk("stalled", wr_valid, 1'b1);
    wr_ready = 1'b1;
    ak = 1'b1;
    for (k = 0; k < 4 && ak; k++) begin
      i_ees_master.start();
      i_ees_master.xfer(dev(1'b0), 1'b1, 1'b0, rx, ak);
      i_ees_master.stop();
    end
    chk("busy end", ak, 1'b0);
    chk("drained", wr_valid, 1'b0);
    for (int i = 0; i < 5; i++) chk("page", mem[{9'h004, 6'(62 + i)}], 8'h10 + i);
    chk("untouched", mem[15'h0103], 8'hff);
  endtask
  // Dummy write, repeated START, read across the top of memory
  task automatic t_read();
    logic [7:0] rx;
    logic ak;
    mem[15'h7fff] = 8'h5a;
    mem[15'h0000] = 8'ha5;
    i_ees_master.start();
    wb(dev(1'b0), 1'b0);
    wb(8'h7f, 1'b0);
    wb(8'hff, 1'b0);
    i_ees_master.start();
    wb(dev(1'b1), 1'b0);
    i_ees_master.xfer(8'hff, 1'b0, 1'b0, rx, ak);
    chk("rd0", rx, 8'h5a);
    i_ees_master.xfer(8'hff, 1'b1, 1'b0, rx, ak);
    chk("rd1", rx, 8'ha5);
    i_ees_master.stop();
  endtask
  // Protected write refused, array untouched, no busy time
  task automatic t_wp();
    wp = 1'b1;
    i_ees_master.start();
    wb(dev(1'b0), 1'b0);
    wb(8'h00, 1'b0);
    wb(8'h40, 1'b0);
    wb(8'h77, 1'b1);
    i_ees_master.stop();
    wp = 1'b0;
    cyc(8);
    chk("wp mem", mem[15'h0040], 8'hff);
    i_ees_master.start();
    wb(dev(1'b0), 1'b0);
    i_ees_master.stop();
  endtask
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
    t_reset();
    t_sel();
    t_glitch();
    t_page();
    t_read();
    t_wp();
    t_reset();
    t_glitch();
    end_sim();
  end
  // Hang guard
  initial begin
    #4000000;
    n_fail++;
    end_sim();
  end
endmodule
